// ### src/async_mem_ctrl.sv
// Asynchronous SRAM and flash access sequencer: setup, strobe, hold and turnaround phases.
// Assumes one request source on clk and a memory that keeps to the wait handshake.
//
// How it works
// - Phase lengths count whole system clock periods.
// - Turnaround gap of programmed periods after accesses.
// - Setup, strobe, hold and turnaround counts come from configuration ports.
// - Read lasts setup plus strobe plus hold.
// - Extended wait adds sixteen periods per count.
// - Chip select leads and trails read strobe.
// - Strobe mode: select follows strobe exactly.
// - Read address valid from setup through hold.
// - Read strobe low exactly strobe periods.
// - Extended read strobe grows sixteen per count.
// - Read strobe rises four after wait release.
// - Write lasts setup plus strobe plus hold.
// - Extended write grows sixteen per count.
// - Chip select leads and trails write strobe.
// - Write address valid from setup through hold.
// - Write data driven from setup through hold.
// - Write strobe low exactly strobe periods.
// - Extended write strobe grows sixteen per count.
// - Write strobe rises four after wait release.
// - Wait count spans 256; bounded by maximum.
`default_nettype none
module async_mem_ctrl
	import async_mem_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Access request
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [BANK_W-1:0] req_bank,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic req_ready,
	// Read return
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid,
	// Configuration
	input wire logic [PHASE_W-1:0] read_setup,
	input wire logic [PHASE_W-1:0] read_strobe,
	input wire logic [PHASE_W-1:0] read_hold,
	input wire logic [PHASE_W-1:0] write_setup,
	input wire logic [PHASE_W-1:0] write_strobe,
	input wire logic [PHASE_W-1:0] write_hold,
	input wire logic [PHASE_W-1:0] turnaround_cycles,
	input wire logic [WAIT_CNT_W-1:0] max_wait_cycles,
	input wire logic extended_wait_enable,
	input wire logic select_strobe_mode,
	// Status
	input wire logic timeout_clear,
	output logic wait_timeout,
	output logic [WAIT_CNT_W-1:0] wait_extension_count,
	// Memory pins
	output logic chip_select_n,
	output logic output_enable_n,
	output logic write_enable_n,
	output logic [ADDR_W-1:0] ext_addr,
	output logic [BANK_W-1:0] bank_addr,
	output logic [DATA_W-1:0] ext_data_out,
	output logic ext_data_oe,
	input wire logic [DATA_W-1:0] ext_data_in,
	input wire logic wait_in
);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	phase_t state_q;
	phase_t state_d;
	logic wait_s;
	logic cnt_load;
	logic [PHASE_W-1:0] cnt_value;
	logic cnt_last;

	// Configuration is latched at acceptance so a change mid-access cannot tear a phase.
	logic [PHASE_W-1:0] su_q, st_q, ho_q, ta_q;
	logic [WAIT_CNT_W-1:0] mw_q;
	logic ew_q, ss_q, wr_q;
	logic [WAIT_PRE_W-1:0] pre_q;
	logic [WAIT_CNT_W-1:0] ewc_q;
	logic ready_q, timeout_q, rd_valid_q;
	logic cs_n_q, oe_n_q, we_n_q, data_oe_q;
	logic [ADDR_W-1:0] addr_q;
	logic [BANK_W-1:0] bank_q;
	logic [DATA_W-1:0] wdata_q, rdata_q;

	wait_sync u_wait_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in(wait_in),
		.sync_out(wait_s)
	);

	phase_counter #(
		.W(PHASE_W)
	) u_phase (
		.clk(clk),
		.reset_n(reset_n),
		.load(cnt_load),
		.value(cnt_value),
		.last(cnt_last)
	);

	// Request decode and the lengths it brings.
	wire accept = req_valid & ready_q & (state_q == ST_IDLE);
	wire [PHASE_W-1:0] n_su = req_write ? write_setup : read_setup;
	wire [PHASE_W-1:0] n_st_raw = req_write ? write_strobe : read_strobe;
	wire [PHASE_W-1:0] n_st = (n_st_raw == '0) ? STROBE_MIN : n_st_raw;
	wire [PHASE_W-1:0] n_ho = req_write ? write_hold : read_hold;

	// Wait blocks of sixteen periods and the timeout bound.
	wire blk_tick = (state_q == ST_WAIT) && (pre_q == WAIT_PRE_LAST);
	wire [WAIT_CNT_W:0] ewc_next = {1'b0, ewc_q} + {{WAIT_CNT_W{1'b0}}, 1'b1};
	wire timeout_hit = blk_tick && (ewc_next >= {1'b0, mw_q});
	wire timeout_set = (state_q == ST_WAIT) && wait_s && timeout_hit;

	// Phase that follows the strobe or the hold; zero-length phases are skipped.
	wire phase_t after_hold = (ta_q != '0) ? ST_TURN : ST_IDLE;
	wire phase_t after_strobe = (ho_q != '0) ? ST_HOLD : after_hold;
	wire [PHASE_W-1:0] after_hold_len = ta_q;
	wire [PHASE_W-1:0] after_strobe_len = (ho_q != '0) ? ho_q : ta_q;
	wire [PHASE_W-1:0] release_len = PHASE_W'(WAIT_RELEASE_CYCLES - 1);

	always_comb
	begin
		state_d = state_q;
		cnt_load = 1'b0;
		cnt_value = '0;
		case (state_q)
			ST_IDLE:
				if (accept)
				begin
					cnt_load = 1'b1;
					state_d = (n_su != '0) ? ST_SETUP : ST_STROBE;
					cnt_value = (n_su != '0) ? n_su : n_st;
				end
			ST_SETUP:
				if (cnt_last)
				begin
					state_d = ST_STROBE;
					cnt_load = 1'b1;
					cnt_value = st_q;
				end
			ST_STROBE:
				if (cnt_last)
				begin
					if (ew_q && wait_s)
						state_d = ST_WAIT;
					else
					begin
						state_d = after_strobe;
						cnt_load = 1'b1;
						cnt_value = after_strobe_len;
					end
				end
			ST_WAIT:
				if (!wait_s)
				begin
					state_d = ST_RELEASE;
					cnt_load = 1'b1;
					cnt_value = release_len;
				end
				else if (timeout_hit)
				begin
					state_d = after_strobe;
					cnt_load = 1'b1;
					cnt_value = after_strobe_len;
				end
			ST_RELEASE:
				if (cnt_last)
				begin
					state_d = after_strobe;
					cnt_load = 1'b1;
					cnt_value = after_strobe_len;
				end
			ST_HOLD:
				if (cnt_last)
				begin
					state_d = after_hold;
					cnt_load = 1'b1;
					cnt_value = after_hold_len;
				end
			ST_TURN:
				if (cnt_last)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// Pin levels are decoded from the next state so every pin is a plain flop.
	wire wr_d = accept ? req_write : wr_q;
	wire ss_d = accept ? select_strobe_mode : ss_q;
	wire active_d = (state_d != ST_IDLE) && (state_d != ST_TURN);
	wire strobe_d = (state_d == ST_STROBE) || (state_d == ST_WAIT) || (state_d == ST_RELEASE);
	wire cs_n_d = ss_d ? !strobe_d : !active_d;
	wire oe_n_d = !(strobe_d && !wr_d);
	wire we_n_d = !(strobe_d && wr_d);
	wire rd_end = (state_q == ST_STROBE || state_q == ST_WAIT || state_q == ST_RELEASE)
		&& !strobe_d && !wr_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= ST_IDLE;
			ready_q <= 1'b0;
			cs_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			data_oe_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ready_q <= (state_d == ST_IDLE);
			cs_n_q <= cs_n_d;
			oe_n_q <= oe_n_d;
			we_n_q <= we_n_d;
			data_oe_q <= active_d && wr_d;
		end
	end

	// Address, bank and write data are loaded once and held across the whole access.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			addr_q <= '0;
			bank_q <= '0;
			wdata_q <= '0;
		end
		else if (accept)
		begin
			addr_q <= req_addr;
			bank_q <= req_bank;
			wdata_q <= req_wdata;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			su_q <= '0;
			st_q <= STROBE_MIN;
			ho_q <= '0;
			ta_q <= '0;
			mw_q <= '0;
			ew_q <= 1'b0;
			ss_q <= 1'b0;
			wr_q <= 1'b0;
		end
		else if (accept)
		begin
			su_q <= n_su;
			st_q <= n_st;
			ho_q <= n_ho;
			ta_q <= turnaround_cycles;
			mw_q <= max_wait_cycles;
			ew_q <= extended_wait_enable;
			ss_q <= select_strobe_mode;
			wr_q <= req_write;
		end
	end

	// Wait extension: each sixteen-period block bumps the count, except the block that hits the timeout bound.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pre_q <= '0;
			ewc_q <= '0;
		end
		else if (accept)
		begin
			pre_q <= '0;
			ewc_q <= '0;
		end
		else if (state_q == ST_WAIT)
		begin
			pre_q <= pre_q + WAIT_PRE_W'(1);
			if (blk_tick && !timeout_hit)
				ewc_q <= ewc_next[WAIT_CNT_W-1:0];
		end
	end

	// A timeout in the same cycle as a clear still leaves the flag set.
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			timeout_q <= 1'b0;
			rd_valid_q <= 1'b0;
			rdata_q <= '0;
		end
		else
		begin
			timeout_q <= timeout_set | (timeout_q & !timeout_clear);
			rd_valid_q <= rd_end;
			if (rd_end)
				rdata_q <= ext_data_in;
		end
	end

	assign req_ready = ready_q;
	assign rd_data = rdata_q;
	assign rd_valid = rd_valid_q;
	assign wait_timeout = timeout_q;
	assign wait_extension_count = ewc_q;
	assign chip_select_n = cs_n_q;
	assign output_enable_n = oe_n_q;
	assign write_enable_n = we_n_q;
	assign ext_addr = addr_q;
	assign bank_addr = bank_q;
	assign ext_data_out = wdata_q;
	assign ext_data_oe = data_oe_q;

	// Checking counters: strobe low time, select lead, access length, turnaround length.
	logic [CHK_W-1:0] lowc_q, leadc_q, accc_q, turnc_q;
	wire strobe_q = !oe_n_q || !we_n_q;
	wire active_q = (state_q != ST_IDLE) && (state_q != ST_TURN);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lowc_q <= '0;
			leadc_q <= '0;
			accc_q <= '0;
			turnc_q <= '0;
		end
		else
		begin
			lowc_q <= strobe_q ? lowc_q + CHK_W'(1) : '0;
			leadc_q <= cs_n_q ? '0 : (strobe_q ? leadc_q : leadc_q + CHK_W'(1));
			accc_q <= active_q ? accc_q + CHK_W'(1) : '0;
			turnc_q <= (state_q == ST_TURN) ? turnc_q + CHK_W'(1) : '0;
		end
	end

	sequence s_wait_seen;
		(state_q == ST_WAIT) && !wait_s;
	endsequence

	sequence s_strobe_up;
		$rose(oe_n_q && we_n_q);
	endsequence

	a_read_strobe_width: assert property ($rose(oe_n_q) && !ew_q |-> lowc_q == CHK_W'(st_q))
		else $error("read strobe width differs from programmed strobe");
	a_write_strobe_width: assert property ($rose(we_n_q) && !ew_q |-> lowc_q == CHK_W'(st_q))
		else $error("write strobe width differs from programmed strobe");
	a_read_select_lead: assert property ($fell(oe_n_q) && !ss_q |-> leadc_q == CHK_W'(su_q))
		else $error("chip select lead before read strobe is wrong");
	a_write_select_lead: assert property ($fell(we_n_q) && !ss_q |-> leadc_q == CHK_W'(su_q))
		else $error("chip select lead before write strobe is wrong");
	a_select_strobe_mode: assert property (ss_q && active_q |-> cs_n_q == (oe_n_q && we_n_q))
		else $error("chip select does not follow the strobe");
	a_wait_release_delay: assert property (s_wait_seen |-> ##4 s_strobe_up)
		else $error("strobe did not rise four cycles after wait release");
	a_access_length: assert property (active_q && state_d inside {ST_IDLE, ST_TURN} && !ew_q
		|-> accc_q + CHK_W'(1) == CHK_W'(su_q) + CHK_W'(st_q) + CHK_W'(ho_q))
		else $error("access length differs from setup plus strobe plus hold");
	a_turnaround_len: assert property ((state_q == ST_TURN) && (state_d != ST_TURN)
		|-> turnc_q + CHK_W'(1) == CHK_W'(ta_q))
		else $error("turnaround gap differs from programmed count");
	a_address_held: assert property (active_q && $past(active_q)
		|-> $stable(addr_q) && $stable(bank_q))
		else $error("address or bank changed inside an access");
	// The data register loads at acceptance, so stability is only asked after the first cycle.
	a_write_data_drive: assert property (active_q && wr_q
		|-> data_oe_q && (!$past(active_q) || $stable(wdata_q)))
		else $error("write data not driven across the access");
	a_timeout_flag: assert property (timeout_set |=> timeout_q && (state_q != ST_WAIT))
		else $error("timeout did not end the strobe and set the flag");

endmodule
`default_nettype wire

// ### src/async_mem_pkg.sv
// Shared constants and state encoding for the asynchronous memory strobe sequencer.
// Assumes a single system clock; every phase count is in whole periods of it.
`default_nettype none
package async_mem_pkg;

	// Memory pin widths.
	localparam int ADDR_W = 21;
	localparam int BANK_W = 2;
	localparam int DATA_W = 16;

	// Width of a programmed phase count and of the wait block count (256 values).
	localparam int PHASE_W = 8;
	localparam int WAIT_CNT_W = 8;

	// One wait block is sixteen system clock periods.
	localparam int WAIT_STEP = 16;
	localparam int WAIT_PRE_W = 4;
	localparam logic [WAIT_PRE_W-1:0] WAIT_PRE_LAST = 4'(WAIT_STEP - 1);

	// Strobe end follows a seen wait release by this many periods.
	localparam int WAIT_RELEASE_CYCLES = 4;

	// Shortest strobe; a programmed zero is stretched to this.
	localparam logic [PHASE_W-1:0] STROBE_MIN = 8'h01;

	// Width of the checking counters beside the sequencer.
	localparam int CHK_W = 12;

	// Sequencer states; the usual path idle-setup-strobe-hold-turn steps in Gray code.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SETUP = 3'h1,
		ST_STROBE = 3'h3,
		ST_HOLD = 3'h7,
		ST_TURN = 3'h5,
		ST_WAIT = 3'h2,
		ST_RELEASE = 3'h6
	} phase_t;

endpackage
`default_nettype wire

// ### src/wait_sync.sv
// Two-stage synchroniser for the memory wait pin.
// Assumes the pin is asynchronous to clk; only the second stage is visible.
`default_nettype none
module wait_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Pin and synchronised level
	input wire logic async_in,
	output logic sync_out
);

	logic meta_q;
	logic sync_q;

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule
`default_nettype wire

// ### src/phase_counter.sv
// Loadable down counter that times one phase of an access.
// Assumes a load of N marks the first of N cycles; last flags the Nth.
`default_nettype none
module phase_counter #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Load and phase end
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic last
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	localparam logic [W-1:0] ONE = W'(1);

	assign cnt_d = load ? value : ((cnt_q != '0) ? cnt_q - ONE : cnt_q);
	assign last = (cnt_q == ONE);

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

endmodule
`default_nettype wire

// ### verification/sram_model.sv
// Behavioural asynchronous SRAM with a wait pin, for the strobe sequencer bench.
// Assumes the sequencer changes its pins at rising clk edges only.
`default_nettype none
module sram_model
	import async_mem_pkg::*;
(
	// Clock
	input wire logic clk,
	// Memory pins
	input wire logic chip_select_n,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic [ADDR_W-1:0] ext_addr,
	input wire logic [DATA_W-1:0] ext_data_out,
	output logic [DATA_W-1:0] ext_data_in,
	output logic wait_in,
	// Strobe cycles for which the memory holds off
	input wire logic [7:0] wait_len
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [DATA_W-1:0] mem [0:15];
	logic [DATA_W-1:0] last_q = 16'h0;
	int wcnt_q = 0;
	wire strobe_low = !chip_select_n && !(output_enable_n && write_enable_n);
	wire reading = !chip_select_n && !output_enable_n;
	// A released bus shows the inverse of its last value, so a late sample cannot pass.
	assign ext_data_in = reading ? mem[ext_addr[3:0]] : ~last_q;
	// Wait is raised only inside the strobe and dropped once the memory is ready.
	assign wait_in = strobe_low && (wcnt_q < wait_len);
	always @(posedge clk)
	begin
		last_q <= ext_data_in;
		wcnt_q <= strobe_low ? wcnt_q + 1 : 0;
		if (!chip_select_n && !write_enable_n)
			mem[ext_addr[3:0]] <= ext_data_out;
	end
endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the asynchronous memory strobe sequencer.
// Assumes one memory model on the pins; config except max_wait_cycles is set with each request.
`default_nettype none
module tb
	import async_mem_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, reset_n = 0, req_valid = 0, req_write = 0, timeout_clear = 0;
	logic [ADDR_W-1:0] req_addr = 21'h0, ext_addr;
	logic [BANK_W-1:0] req_bank = 2'h0, bank_addr;
	logic [DATA_W-1:0] req_wdata = 16'h0, rd_data, ext_data_out, ext_data_in;
	logic [PHASE_W-1:0] read_setup = 8'h0, read_strobe = 8'h0, read_hold = 8'h0;
	logic [PHASE_W-1:0] write_setup = 8'h0, write_strobe = 8'h0, write_hold = 8'h0;
	logic [PHASE_W-1:0] turnaround_cycles = 8'h0;
	logic [7:0] max_wait_cycles = 8'hff, wait_len = 8'h0, wait_extension_count;
	logic extended_wait_enable = 0, select_strobe_mode = 0, req_ready, rd_valid;
	logic wait_timeout, chip_select_n, output_enable_n, write_enable_n, ext_data_oe, wait_in;
	logic [DATA_W-1:0] exp_mem [0:15];
	int num_errors = 0, checked = 0, cycles = 0, tests = 0;

	async_mem_ctrl async_mem_ctrl_inst (.clk, .reset_n, .req_valid, .req_write, .req_addr,
		.req_bank, .req_wdata, .req_ready, .rd_data, .rd_valid, .read_setup, .read_strobe,
		.read_hold, .write_setup, .write_strobe, .write_hold, .turnaround_cycles,
		.max_wait_cycles, .extended_wait_enable, .select_strobe_mode, .timeout_clear,
		.wait_timeout, .wait_extension_count, .chip_select_n, .output_enable_n,
		.write_enable_n, .ext_addr, .bank_addr, .ext_data_out, .ext_data_oe, .ext_data_in,
		.wait_in);
	sram_model sram_model_inst (.clk, .chip_select_n, .output_enable_n, .write_enable_n,
		.ext_addr, .ext_data_out, .ext_data_in, .wait_in, .wait_len);

	initial
		forever #2 clk = ~clk;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// One access; wx is the expected wait block count, or -1 where a timeout is due.
	task automatic access(input logic w, input logic [3:0] a, input logic [15:0] d,
		input int su, st, ho, ta, input logic ss, ew, input int wl, wx);
		int n, csl, sl, s1, c1, rv, bad, wf, rs, stx;
		logic [DATA_W-1:0] got;
		logic wp;
		{csl, sl, s1, c1, rv, bad, wf, rs} = '0;
		wp = 0;
		got = 16'h0;
		stx = (st == 0) ? 1 : st;
		req_valid = 1;
		req_write = w;
		req_addr = {17'h0, a};
		req_bank = a[1:0];
		req_wdata = d;
		{read_setup, write_setup} = {2{su[7:0]}};
		{read_strobe, write_strobe} = {2{st[7:0]}};
		{read_hold, write_hold} = {2{ho[7:0]}};
		turnaround_cycles = ta[7:0];
		select_strobe_mode = ss;
		extended_wait_enable = ew;
		wait_len = wl[7:0];
		while (req_ready !== 1'b1)
		begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		req_valid = 0;
		for (n = 1; req_ready !== 1'b1 && n < 400; n++)
		begin
			csl += (chip_select_n === 1'b0);
			if (chip_select_n === 1'b0 && c1 == 0)
				c1 = n;
			if ((w ? write_enable_n : output_enable_n) === 1'b0)
			begin
				sl++;
				rs = n + 1;
				if (s1 == 0)
					s1 = n;
			end
			if (wp && wait_in === 1'b0 && wf == 0)
				wf = n;
			wp = wait_in;
			if (rd_valid === 1'b1)
				rv = n;
			if (rd_valid === 1'b1)
				got = rd_data;
			if ((chip_select_n === 1'b0 || n <= su) && (ext_addr !== req_addr
				|| bank_addr !== a[1:0] || w && (ext_data_oe !== 1'b1 || ext_data_out !== d)))
				bad++;
			@(posedge clk);
			#1;
		end
		check(s1, su + 1);
		check(c1, ss ? su + 1 : 1);
		check(csl, ss ? sl : su + sl + ho);
		check(n, su + sl + ho + ta + 1);
		check(bad, 0);
		check(wait_timeout, wx < 0);
		if (wx >= 0)
			check(wait_extension_count, wx);
		if (wx == 0)
			check(sl, stx);
		if (wx > 0)
			check(sl >= stx + 16 * wx, 1);
		if (wx > 0)
			check(rs - wf >= 5 && rs - wf <= 7, 1);
		if (wx < 0)
			check(sl < wl, 1);
		if (wx < 0)
			check(sl, stx + 16 * max_wait_cycles);
		if (!w)
			check(rv, su + sl + 1);
		if (!w)
			check(got, exp_mem[a]);
		if (w)
			exp_mem[a] = d;
		tests++;
		$display("test %0d done", tests);
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	initial
	begin
		repeat (10) @(posedge clk);
		#1 reset_n = 1;
		@(posedge clk);
		#1;
		access(1, 4'h3, 16'ha5c3, 2, 3, 1, 2, 0, 0, 0, 0);
		access(0, 4'h3, 16'h0, 2, 3, 1, 2, 0, 0, 0, 0);
		access(1, 4'h5, 16'h5a3c, 0, 0, 0, 1, 1, 0, 0, 0);
		access(0, 4'h5, 16'h0, 1, 2, 2, 0, 1, 0, 5, 0);
		access(1, 4'h9, 16'h1234, 3, 1, 3, 3, 0, 1, 0, 0);
		access(0, 4'h9, 16'h0, 1, 4, 1, 1, 0, 1, 42, 2);
		access(1, 4'hc, 16'hbeef, 1, 4, 1, 1, 0, 1, 42, 2);
		max_wait_cycles = 8'h01;
		access(0, 4'hc, 16'h0, 1, 4, 1, 1, 0, 1, 100, -1);
		timeout_clear = 1;
		@(posedge clk);
		#1;
		timeout_clear = 0;
		check(wait_timeout, 0);
		print_verdict();
	end
endmodule
`default_nettype wire
